// [hw/ecd_regs.svh]
// Behaviour
// - busy flag bit 30 reads 1 while a download write is crossing, else 0
// - busy stays set until the byte is safely inside the core clock domain
// - config flag set: data writes load the core buffer; data reads undefined
// - config flag clear: data writes dropped, data reads return zero
// - data register usable only while core enable is 0; else accesses ignored
// - data register holds 8-bit byte in bits 7-0; bits 31-8 read zero
// - address register holds 9-bit RAM address; bits 29-9 read zero
// - config flag set at reset, clears after the core takes the last byte
`ifndef ECD_REGS_SVH
`define ECD_REGS_SVH

`define ECD_ADDR_W 32
`define ECD_DATA_W 32
`define ECD_OFS_ADDRESS 32'h00212010
`define ECD_OFS_DATA 32'h00212014

`define ECD_RAM_ADDR_W 9
`define ECD_BYTE_W 8
`define ECD_BIT_CFG 31
`define ECD_BIT_BUSY 30

`define ECD_RST_RAM_ADDR 9'h000
`define ECD_RST_BYTE 8'h00
`define ECD_RST_CFG 1'b1
`define ECD_RST_RDATA 32'h00000000

`endif

// [hw/ecd_pkg.sv]
`include "ecd_regs.svh"

package ecd_pkg;

  typedef struct packed {
    logic [`ECD_ADDR_W-1:0] addr;
    logic [`ECD_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ecd_bus_req_t;

  typedef struct packed {
    logic wr_toggle;
    logic [`ECD_RAM_ADDR_W-1:0] ram_addr;
    logic [`ECD_BYTE_W-1:0] byte_data;
  } ecd_core_req_t;

  typedef struct packed {
    logic [`ECD_RAM_ADDR_W-1:0] target_ram_address_field;
    logic cfg_flag;
    logic req_toggle;
    logic ack_meta;
    logic ack_sync;
    logic done_meta;
    logic done_sync;
    logic [`ECD_RAM_ADDR_W-1:0] out_addr;
    logic [`ECD_BYTE_W-1:0] out_byte;
    logic [`ECD_DATA_W-1:0] rdata;
  } ecd_state_t;

endpackage

// [hw/ecd_download.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "ecd_regs.svh"

module ecd_download (
  input wire logic clock,
  input wire logic reset_n,
  input wire ecd_pkg::ecd_bus_req_t bus_req,
  output logic [`ECD_DATA_W-1:0] bus_rdata,
  input wire logic core_enable_bit,
  output ecd_pkg::ecd_core_req_t core_req,
  input wire logic core_ack_toggle,
  input wire logic core_config_done
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic hit(input logic [`ECD_ADDR_W-1:0] a, input logic [`ECD_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  ecd_pkg::ecd_state_t state_reg;
  ecd_pkg::ecd_state_t state_next;
  logic write_pending_flag;
  logic addr_hit;
  logic data_hit;
  logic data_open;

  // a write crossing is outstanding while the returned toggle lags
  assign write_pending_flag = state_reg.req_toggle ^ state_reg.ack_sync;
  assign addr_hit = hit(bus_req.addr, `ECD_OFS_ADDRESS);
  assign data_hit = hit(bus_req.addr, `ECD_OFS_DATA);
  assign data_open = data_hit && !core_enable_bit;

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = `ECD_RST_RDATA;

    // only the second stage is looked at by the logic
    state_next.ack_meta = core_ack_toggle;
    state_next.ack_sync = state_reg.ack_meta;
    state_next.done_meta = core_config_done;
    state_next.done_sync = state_reg.done_meta;

    // config flag drops once the core reports the last byte and nothing is in flight
    if (state_reg.cfg_flag && state_reg.done_sync && !write_pending_flag)
    begin
      state_next.cfg_flag = 1'b0;
    end

    if (bus_req.wr)
    begin
      if (addr_hit)
      begin
        state_next.target_ram_address_field = bus_req.wdata[`ECD_RAM_ADDR_W-1:0];
      end
      // a second write while busy is dropped rather than corrupting the crossing
      else if (data_open && state_reg.cfg_flag && !write_pending_flag)
      begin
        state_next.out_byte = bus_req.wdata[`ECD_BYTE_W-1:0];
        state_next.out_addr = state_reg.target_ram_address_field;
        state_next.req_toggle = !state_reg.req_toggle;
      end
    end

    if (bus_req.rd)
    begin
      if (addr_hit)
      begin
        state_next.rdata[`ECD_BIT_CFG] = state_reg.cfg_flag;
        state_next.rdata[`ECD_BIT_BUSY] = write_pending_flag;
        state_next.rdata[`ECD_RAM_ADDR_W-1:0] = state_reg.target_ram_address_field;
      end
      // undefined and descriptor-mode data reads both answer zero
      else if (data_open)
      begin
        state_next.rdata = `ECD_RST_RDATA;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg.target_ram_address_field <= `ECD_RST_RAM_ADDR;
      state_reg.cfg_flag <= `ECD_RST_CFG;
      state_reg.req_toggle <= 1'b0;
      state_reg.ack_meta <= 1'b0;
      state_reg.ack_sync <= 1'b0;
      state_reg.done_meta <= 1'b0;
      state_reg.done_sync <= 1'b0;
      state_reg.out_addr <= `ECD_RST_RAM_ADDR;
      state_reg.out_byte <= `ECD_RST_BYTE;
      state_reg.rdata <= `ECD_RST_RDATA;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata = state_reg.rdata;
  // address and byte are held stable while the toggle crosses
  assign core_req.wr_toggle = state_reg.req_toggle;
  assign core_req.ram_addr = state_reg.out_addr;
  assign core_req.byte_data = state_reg.out_byte;

endmodule

// [verif/ecd_download_assertions.sv]
`timescale 1ns/10ps
module ecd_download_assertions (
  input logic clock,
  input logic reset_n,
  input ecd_pkg::ecd_bus_req_t bus_req,
  input logic [31:0] bus_rdata,
  input logic core_enable_bit,
  input ecd_pkg::ecd_core_req_t core_req,
  input logic core_ack_toggle
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire ra = bus_req.rd && bus_req.addr == 32'h00212010;
  wire m = core_ack_toggle == core_req.wr_toggle;
  AST_IDLE: assert property (!$past(bus_req.rd) |-> !bus_rdata) else $error("rdata idle");
  AST_DATA: assert property (bus_req.rd && bus_req.addr == 32'h00212014 |=> !bus_rdata) else $error("data");
  AST_RSVD: assert property (ra |=> !bus_rdata[29:9]) else $error("rsvd");
  AST_TOG: assert property ($changed(core_req.wr_toggle) |->
    $past(bus_req.wr && !core_enable_bit)) else $error("tog");
  AST_HOLD: assert property ($stable(core_req.wr_toggle) |-> $stable(core_req)) else $error("hold");
  AST_BSET: assert property ($changed(core_req.wr_toggle) ##1 ra |=> bus_rdata[30]) else $error("set");
  AST_BHOLD: assert property (ra && !m |=> bus_rdata[30]) else $error("busy");
  AST_BCLR: assert property (m [*4] ##0 ra |=> !bus_rdata[30]) else $error("clr");
endmodule
bind ecd_download ecd_download_assertions ecd_download_assertions_i (.*);

// [verif/ecd_core_model.sv]
`timescale 1ns/10ps
module ecd_core_model (
  input logic clock,
  input logic reset_n,
  input ecd_pkg::ecd_core_req_t core_req,
  input logic [3:0] lat,
  output logic core_ack_toggle,
  output logic core_config_done
);
  logic [3:0] wait_reg, taken_reg;
  // slow echo, so busy spans polls
  always_ff @(posedge clock)
    wait_reg <= reset_n && core_req.wr_toggle != core_ack_toggle ? wait_reg + 4'h1 : 4'h0;
  always_ff @(posedge clock)
    if (!reset_n || wait_reg == lat)
      {core_ack_toggle, taken_reg} <= reset_n ? {core_req.wr_toggle, taken_reg + 4'h1} : 5'h00;
  assign core_config_done = taken_reg == 4'h5;
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clock = 0, reset_n = 0, core_enable_bit = 0, core_ack_toggle, core_config_done;
  logic [3:0] lat = 4'h4;
  logic [31:0] bus_rdata, q, w, adr = 32'h00212010, dat = 32'h00212014;
  ecd_pkg::ecd_bus_req_t bus_req = '0;
  ecd_pkg::ecd_core_req_t core_req;
  int errors = 0, comparisons = 0, seed = 32'hFEC0FCEF, i, k;
  always #12.5 clock = ~clock;
  ecd_download ecd_download_i (.*);
  ecd_core_model ecd_core_model_i (.*);
  task chk(logic [31:0] s, e);
    comparisons++;
    errors += s !== e;
    if (s !== e)
      $display("[ERR] %0t %h %h", $time, s, e);
  endtask
  task end_of_test(int h);
    $display("errors %0d comparisons %0d", errors + h, comparisons);
    if (errors + h == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task acc(logic [31:0] a, d, logic wr);
    @(posedge clock) bus_req <= '{a, d, wr, !wr};
    @(posedge clock) bus_req <= '0;
    @(negedge clock) q = bus_rdata;
  endtask
  // bounded wait for a status bit to drop
  task poll(int n);
    for (i = 0, q = '1; q[n] !== 1'b0; i++)
      if (i < 60)
        acc(adr, 0, 0);
      else
        end_of_test(1);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1;
    acc(adr, 0, 0);
    chk(q, 32'h80000000);
    core_enable_bit <= 1;
    acc(dat, 1, 1);
    chk(core_req.wr_toggle, 0);
    core_enable_bit <= 0;
    for (k = 0; k < 5; k++)
    begin
      w = k ? $random(seed) : '1;
      lat <= 4'h4 + w[11:10];
      acc(adr, w, 1);
      acc(dat, w >> 16, 1);
      chk(core_req, {~k[0], w[8:0], w[23:16]});
      acc(dat, ~w >> 16, 1);
      chk(core_req, {~k[0], w[8:0], w[23:16]});
      acc(adr, 0, 0);
      chk(q, {2'h3, 21'h0, w[8:0]});
      poll(30);
    end
    $display("download test done");
    poll(31);
    acc(dat, 1, 1);
    chk(core_req.wr_toggle, 1);
    acc(dat, 0, 0);
    chk(q, 0);
    acc(32'h00212018, 0, 0);
    chk(q, 0);
    $display("config test done");
    end_of_test(0);
  end
endmodule
